// File: hw/sfl_map.svh
// register offsets, field positions, reset values and sizes of the serial status block
// assumes a 32-bit AXI4-Lite slave port with byte addresses
`ifndef SFL_MAP_SVH
`define SFL_MAP_SVH

// ==========================================================
// register byte offsets
`define SFL_OFS_STATUS 12'h000
`define SFL_OFS_MASK 12'h004
`define SFL_OFS_CTRL 12'h008

// ==========================================================
// status and mask field positions
`define SFL_BIT_TCF 0
`define SFL_BIT_RUN 1
`define SFL_BIT_EOQ 2
`define SFL_BIT_TX_UNDERFLOW_FLAG 3
`define SFL_BIT_TX_FILL_REQUEST_FLAG 4
`define SFL_BIT_RX_OVERFLOW_FLAG 5
`define SFL_BIT_RX_DRAIN_REQUEST_FLAG 6
`define SFL_FLAG_W 7
`define SFL_STICKY_MASK 7'h6d
// every request source but the run state can be masked
`define SFL_MASK_BITS 7'h7d
`define SFL_POS_TXCNT 8
`define SFL_POS_TXIDX 12
`define SFL_POS_RXCNT 16
`define SFL_POS_RXIDX 20

// ==========================================================
// control field positions and reset values
`define SFL_CTRL_START 0
`define SFL_CTRL_HALT 1
`define SFL_CTRL_SLAVE 2
`define SFL_CTRL_FMSZ_LO 8
`define SFL_FMSZ_RESET 5'h07
`define SFL_FMSZ_MIN 5'h03

// ==========================================================
// fifo sizes
`define SFL_CNT_W 4
`define SFL_FIFO_DEPTH 4'h4

// ==========================================================
// bus answers
`define SFL_RESP_OKAY 2'h0
`define SFL_RESP_SLVERR 2'h2

`endif

// File: hw/sfl_pkg.sv
// types shared by the serial status block
// assumes sfl_map.svh is on the include path
package sfl_pkg;
  `include "sfl_map.svh"

  typedef logic [`SFL_CNT_W-1:0] sfl_cnt_t;
  typedef logic [`SFL_FLAG_W-1:0] sfl_flags_t;

  typedef enum logic {
    SFL_RD_IDLE,
    SFL_RD_RESP
  } sfl_rd_state_t;
endpackage

// File: hw/sfl_link_if.sv
// carries frame events from the pin monitor to the status core
// assumes both ends run on aclk
interface sfl_link_if;
  import sfl_pkg::*;
  logic frame_start;
  logic last_bit;
  logic [4:0] frame_size;

  modport mon (
    output frame_start,
    output last_bit,
    input frame_size
  );
  modport core (
    input frame_start,
    input last_bit,
    output frame_size
  );
endinterface

// File: hw/sfl_link_mon.sv
// watches the serial pins and reports frame start and last sampled bit
// assumes sck idles low and data are sampled on the rising sck edge
module sfl_link_mon
  import sfl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sck,
  input wire logic cs_n,
  sfl_link_if.mon link
);
  // ==========================================================
  // pin synchronisers
  logic [2:0] sck_q, sck_d;
  logic [2:0] cs_q, cs_d;
  logic [4:0] bit_q, bit_d;
  logic start_q, start_d;
  logic last_q, last_d;
  logic rise;

  always_comb begin
    sck_d = {sck_q[1:0], sck};
    cs_d = {cs_q[1:0], cs_n};
    // stage 1 and 2 form the synchroniser, stage 2 vs 3 finds edges
    rise = sck_q[1] && !sck_q[2] && !cs_q[1];
    start_d = cs_q[2] && !cs_q[1];
    last_d = 1'b0;
    bit_d = bit_q;
    if (start_d) begin
      bit_d = 5'h00;
    end else if (rise) begin
      if (bit_q == link.frame_size) begin
        last_d = 1'b1;
        bit_d = 5'h00;
      end else begin
        bit_d = bit_q + 5'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q <= 3'h0;
      cs_q <= 3'h7;
      bit_q <= 5'h00;
      start_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      sck_q <= sck_d;
      cs_q <= cs_d;
      bit_q <= bit_d;
      start_q <= start_d;
      last_q <= last_d;
    end
  end

  assign link.frame_start = start_q;
  assign link.last_bit = last_q;
endmodule

// File: hw/sfl_top.sv
// status flags, fifo counters and run state of the serial block, AXI4-Lite slave
// assumes push, pop, load and dma acks are one-cycle pulses on aclk; pins are async
//
// Contract
// - set done flag at last bit; w1c
// - run state 1 running, 0 stopped
// - set queue end at last bit with command bit
// - queue end clears run state; w1c
// - no queue end flag in slave mode
// - slave start with empty tx sets underflow
// - fill flag while tx not full; ack clears
// - start with rx and shifter full: overflow
// - drain flag while rx nonempty; ack clears
// - tx count up on push, down on load
// - tx next index advances on load
// - rx count down on pop, up at last bit
// - rx read index advances on pop
// - writing zero to a flag does nothing
// - flags exported as request sources
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
module sfl_top
  import sfl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic tx_push,
  input wire logic tx_load,
  input wire logic queue_end_command_bit,
  input wire logic rx_pop,
  input wire logic tx_dma_ack,
  input wire logic rx_dma_ack,
  output logic [6:0] status_flags,
  output logic irq
);
  sfl_link_if link ();

  sfl_link_mon u_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .sck(sck),
    .cs_n(cs_n),
    .link(link)
  );

  // ==========================================================
  // bus write channel
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [11:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic wr_fire;

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    if (s_axi_awvalid && awready_q) begin
      aw_hold_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      bvalid_d = 1'b1;
      bresp_d = (waddr_q == `SFL_OFS_STATUS || waddr_q == `SFL_OFS_MASK || waddr_q == `SFL_OFS_CTRL) ?
                `SFL_RESP_OKAY : `SFL_RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
    end
    // one write in flight: channels reopen only after the response is taken
    awready_d = !aw_hold_d;
    wready_d = !w_hold_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      waddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `SFL_RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // ==========================================================
  // status core
  logic wr_status, wr_mask, wr_ctrl;
  logic [`SFL_FLAG_W-1:0] w1c;
  sfl_flags_t flags_q, flags_d, mask_q, mask_d;
  sfl_cnt_t tx_cnt_q, tx_cnt_d, tx_idx_q, tx_idx_d, rx_cnt_q, rx_cnt_d, rx_idx_q, rx_idx_d;
  logic slave_q, slave_d, eoq_exec_q, eoq_exec_d, shift_full_q, shift_full_d;
  logic [4:0] fmsz_q, fmsz_d;
  logic irq_q, irq_d;
  logic tx_full, rx_full, push_ok, load_ok, pop_ok, capture;

  always_comb begin
    wr_status = wr_fire && waddr_q == `SFL_OFS_STATUS && wstrb_q[0];
    wr_mask = wr_fire && waddr_q == `SFL_OFS_MASK && wstrb_q[0];
    wr_ctrl = wr_fire && waddr_q == `SFL_OFS_CTRL;
    w1c = wr_status ? (wdata_q[`SFL_FLAG_W-1:0] & `SFL_STICKY_MASK) : '0;
    tx_full = tx_cnt_q == `SFL_FIFO_DEPTH;
    rx_full = rx_cnt_q == `SFL_FIFO_DEPTH;
    push_ok = tx_push && !tx_full;
    load_ok = tx_load && tx_cnt_q != '0;
    pop_ok = rx_pop && rx_cnt_q != '0;
    capture = link.last_bit && (!rx_full || (pop_ok && !shift_full_q));
    flags_d = flags_q & ~w1c;
    mask_d = mask_q;
    slave_d = slave_q;
    fmsz_d = fmsz_q;
    eoq_exec_d = eoq_exec_q;
    shift_full_d = shift_full_q;
    if (wr_mask) begin
      mask_d = wdata_q[`SFL_FLAG_W-1:0] & `SFL_MASK_BITS;
    end
    if (wr_ctrl && wstrb_q[0]) begin
      slave_d = wdata_q[`SFL_CTRL_SLAVE];
    end
    if (wr_ctrl && wstrb_q[1]) begin
      fmsz_d = wdata_q[`SFL_CTRL_FMSZ_LO +: 5] < `SFL_FMSZ_MIN ? `SFL_FMSZ_MIN : wdata_q[`SFL_CTRL_FMSZ_LO +: 5];
    end
    if (wr_ctrl && wstrb_q[0] && wdata_q[`SFL_CTRL_START]) begin
      flags_d[`SFL_BIT_RUN] = 1'b1;
    end
    if (wr_ctrl && wstrb_q[0] && wdata_q[`SFL_CTRL_HALT]) begin
      flags_d[`SFL_BIT_RUN] = 1'b0;
    end
    if (load_ok) begin
      eoq_exec_d = queue_end_command_bit;
    end
    if (link.last_bit) begin
      flags_d[`SFL_BIT_TCF] = 1'b1;
    end
    if (link.last_bit && eoq_exec_q && !slave_q) begin
      flags_d[`SFL_BIT_EOQ] = 1'b1;
      flags_d[`SFL_BIT_RUN] = 1'b0;
      eoq_exec_d = 1'b0;
    end
    if (link.frame_start && slave_q && tx_cnt_q == '0) begin
      flags_d[`SFL_BIT_TX_UNDERFLOW_FLAG] = 1'b1;
    end
    if (link.frame_start && rx_full && shift_full_q) begin
      flags_d[`SFL_BIT_RX_OVERFLOW_FLAG] = 1'b1;
    end
    // a word that finds the fifo full waits in the shift register until a pop frees a slot
    if (link.last_bit && rx_full && (!pop_ok || shift_full_q)) begin
      shift_full_d = 1'b1;
    end else if (pop_ok && shift_full_q) begin
      shift_full_d = 1'b0;
    end
    tx_cnt_d = tx_cnt_q + sfl_cnt_t'(push_ok) - sfl_cnt_t'(load_ok);
    tx_idx_d = load_ok ? (tx_idx_q == `SFL_FIFO_DEPTH - 4'h1 ? '0 : tx_idx_q + 4'h1) : tx_idx_q;
    // rx count, shifter word moves in on pop
    rx_cnt_d = rx_cnt_q - sfl_cnt_t'(pop_ok) + sfl_cnt_t'(capture || (pop_ok && shift_full_q));
    rx_idx_d = pop_ok ? (rx_idx_q == `SFL_FIFO_DEPTH - 4'h1 ? '0 : rx_idx_q + 4'h1) : rx_idx_q;
    if (tx_cnt_d != `SFL_FIFO_DEPTH) begin
      flags_d[`SFL_BIT_TX_FILL_REQUEST_FLAG] = 1'b1;
    end else if (tx_dma_ack) begin
      flags_d[`SFL_BIT_TX_FILL_REQUEST_FLAG] = 1'b0;
    end else begin
      flags_d[`SFL_BIT_TX_FILL_REQUEST_FLAG] = flags_q[`SFL_BIT_TX_FILL_REQUEST_FLAG] && !(wr_status && wdata_q[`SFL_BIT_TX_FILL_REQUEST_FLAG]);
    end
    // drain flag follows content; a pop before the clear keeps it honest
    if (rx_cnt_d != '0) begin
      flags_d[`SFL_BIT_RX_DRAIN_REQUEST_FLAG] = 1'b1;
    end else if (rx_dma_ack) begin
      flags_d[`SFL_BIT_RX_DRAIN_REQUEST_FLAG] = 1'b0;
    end else begin
      flags_d[`SFL_BIT_RX_DRAIN_REQUEST_FLAG] = flags_q[`SFL_BIT_RX_DRAIN_REQUEST_FLAG] && !(wr_status && wdata_q[`SFL_BIT_RX_DRAIN_REQUEST_FLAG]);
    end
    irq_d = |(flags_d & mask_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
      mask_q <= '0;
      slave_q <= 1'b0;
      fmsz_q <= `SFL_FMSZ_RESET;
      eoq_exec_q <= 1'b0;
      shift_full_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_idx_q <= '0;
      rx_cnt_q <= '0;
      rx_idx_q <= '0;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      mask_q <= mask_d;
      slave_q <= slave_d;
      fmsz_q <= fmsz_d;
      eoq_exec_q <= eoq_exec_d;
      shift_full_q <= shift_full_d;
      tx_cnt_q <= tx_cnt_d;
      tx_idx_q <= tx_idx_d;
      rx_cnt_q <= rx_cnt_d;
      rx_idx_q <= rx_idx_d;
      irq_q <= irq_d;
    end
  end

  assign link.frame_size = fmsz_q;

  // ==========================================================
  // bus read channel
  sfl_rd_state_t rd_q, rd_d;
  logic arready_q, arready_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic rvalid_q, rvalid_d;

  always_comb begin
    rd_d = rd_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    unique case (rd_q)
      SFL_RD_IDLE: begin
        if (s_axi_arvalid && arready_q) begin
          rd_d = SFL_RD_RESP;
          rresp_d = `SFL_RESP_OKAY;
          rdata_d = 32'h0000_0000;
          if (s_axi_araddr == `SFL_OFS_STATUS) begin
            rdata_d[`SFL_FLAG_W-1:0] = flags_q;
            rdata_d[`SFL_POS_TXCNT +: 4] = tx_cnt_q;
            rdata_d[`SFL_POS_TXIDX +: 4] = tx_idx_q;
            rdata_d[`SFL_POS_RXCNT +: 4] = rx_cnt_q;
            rdata_d[`SFL_POS_RXIDX +: 4] = rx_idx_q;
          end else if (s_axi_araddr == `SFL_OFS_MASK) begin
            rdata_d[`SFL_FLAG_W-1:0] = mask_q;
          end else if (s_axi_araddr == `SFL_OFS_CTRL) begin
            rdata_d[`SFL_CTRL_SLAVE] = slave_q;
            rdata_d[`SFL_CTRL_FMSZ_LO +: 5] = fmsz_q;
          end else begin
            rresp_d = `SFL_RESP_SLVERR;
          end
        end
      end
      SFL_RD_RESP: begin
        if (s_axi_rready) begin
          rd_d = SFL_RD_IDLE;
        end
      end
    endcase
    arready_d = rd_d == SFL_RD_IDLE;
    rvalid_d = rd_d == SFL_RD_RESP;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_q <= SFL_RD_IDLE;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SFL_RESP_OKAY;
    end else begin
      rd_q <= rd_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign status_flags = flags_q;
  assign irq = irq_q;
endmodule

// File: dv/sfl_top_properties.sv
// checker of the serial status block, watching only its top ports
// assumes one aclk domain with a synchronous active-low reset
module sfl_top_checker
  import sfl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic cs_n,
  input wire logic [6:0] status_flags,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // done, queue end, underflow and overflow flags only fall when a status write lands; flag and answer move at the same edge
  done_clr_a: assert property (
    $fell(status_flags[0]) |-> s_axi_bvalid)
    else $error("done flag fell without a write");
  qend_clr_a: assert property (
    $fell(status_flags[2]) |-> s_axi_bvalid)
    else $error("queue end flag fell without a write");
  under_clr_a: assert property (
    $fell(status_flags[3]) |-> s_axi_bvalid)
    else $error("underflow flag fell without a write");
  over_clr_a: assert property (
    $fell(status_flags[5]) |-> s_axi_bvalid)
    else $error("overflow flag fell without a write");
  // ==========================================================
  // run state and frame events
  run_start_a: assert property (
    $rose(status_flags[1]) |-> s_axi_bvalid)
    else $error("run state rose without a write");
  qend_stop_a: assert property (
    $rose(status_flags[2]) |-> !status_flags[1])
    else $error("run state kept at queue end");
  done_frame_a: assert property (
    $rose(status_flags[0]) |-> !$past(cs_n, 3))
    else $error("done flag set outside a frame");
  under_frame_a: assert property (
    $rose(status_flags[3]) |-> !$past(cs_n, 3))
    else $error("underflow set outside a frame");
  // run state is not maskable, so it never explains the interrupt
  irq_src_a: assert property (
    irq |-> |(status_flags & 7'h7d))
    else $error("interrupt without a set flag");
  bresp_time_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule

bind sfl_top sfl_top_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .cs_n, .status_flags, .irq);

// File: dv/sfl_spi_peer.sv
// external serial master driving frame select and serial clock
// assumes sck idles low and stands still between frames
module sfl_spi_peer (
  output logic sck,
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
  end
  // 800 ns period, select held a full period on both sides of the bits
  task automatic frame(input int bits);
    cs_n = 1'b0;
    #800;
    repeat (bits) begin
      #400 sck = 1'b1;
      #400 sck = 1'b0;
    end
    #800 cs_n = 1'b1;
    #800;
  endtask
endmodule

// File: dv/test_spi_status_flags_fifo_counters.sv
// self-checking bench of the serial status block
// assumes sfl_map.svh on the include path and a 100 ns aclk
`include "sfl_map.svh"
module test_spi_status_flags_fifo_counters;
  timeunit 1ns;
  timeprecision 1ns;
  import sfl_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, rng = 3, m;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic tx_push = 0, tx_load = 0, queue_end_command_bit = 0, rx_pop = 0, tx_dma_ack = 0, rx_dma_ack = 0;
  logic [6:0] status_flags;
  wire sck, cs_n;
  int failures = 0, samples_checked = 0, cyc = 0, n, tc = 0, ti = 0, rc = 0, ri = 0;

  sfl_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sck(sck), .cs_n(cs_n), .tx_push(tx_push), .tx_load(tx_load),
    .queue_end_command_bit(queue_end_command_bit), .rx_pop(rx_pop), .tx_dma_ack(tx_dma_ack),
    .rx_dma_ack(rx_dma_ack), .status_flags(status_flags), .irq(irq));
  sfl_spi_peer u_peer (.sck(sck), .cs_n(cs_n));

  initial forever #50 aclk = ~aclk;
  // ==========================================================
  // helpers
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function logic [31:0] st(input logic [6:0] f);
    return {8'h00, 4'(ri), 4'(rc), 4'(ti), 4'(tc), 1'b0, f};
  endfunction
  task report_and_stop;
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    rs = s_axi_bresp;
  endtask
  task rdw(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // one-cycle event pulses: push, load, end-of-queue bit, pop, tx ack, rx ack
  task ev(input logic [5:0] v);
    @(posedge aclk);
    {tx_push, tx_load, queue_end_command_bit, rx_pop, tx_dma_ack, rx_dma_ack} <= v;
    @(posedge aclk);
    {tx_push, tx_load, queue_end_command_bit, rx_pop, tx_dma_ack, rx_dma_ack} <= 6'h00;
  endtask
  task cs(input logic [6:0] f);
    rdw(`SFL_OFS_STATUS);
    chk(rd, st(f), "status");
    chk({25'h0, status_flags}, {25'h0, f}, "flag pins");
  endtask
  task irq_is(input logic e);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e}, "irq");
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      report_and_stop;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    cs(7'h10);
    rdw(`SFL_OFS_MASK);
    chk(rd, 32'h0000_0000, "mask reset");
    rdw(12'h00c);
    chk({30'h0, rs}, 32'h0000_0002, "unmapped resp");
    wr(12'h00c, 32'h0000_007f);
    chk({30'h0, rs}, 32'h0000_0002, "unmapped write resp");
    rng = xs(rng);
    n = int'(rng % 3) + 1;
    repeat (n) ev(6'h20);
    tc = n;
    cs(7'h10);
    repeat (5 - n) ev(6'h20);
    tc = 4;
    wr(`SFL_OFS_STATUS, 32'h0000_0000);
    cs(7'h10);
    ev(6'h02);
    cs(7'h00);
    wr(`SFL_OFS_CTRL, 32'h0000_0701);
    cs(7'h02);
    ev(6'h10);
    ev(6'h30);
    tc = 3;
    ti = 2;
    cs(7'h12);
    ev(6'h18);
    tc = 2;
    ti = 3;
    cs(7'h12);
    u_peer.frame(8);
    rc = 1;
    cs(7'h55);
    wr(`SFL_OFS_MASK, 32'h0000_0001);
    irq_is(1'b1);
    wr(`SFL_OFS_STATUS, 32'h0000_0005);
    irq_is(1'b0);
    cs(7'h50);
    rng = xs(rng);
    m = rng & 32'h0000_007d;
    wr(`SFL_OFS_MASK, m);
    irq_is(|(m[6:0] & 7'h50));
    // the fill flag alone must be able to raise the interrupt
    wr(`SFL_OFS_MASK, 32'h0000_0010);
    irq_is(1'b1);
    ev(6'h04);
    rc = 0;
    ri = 1;
    cs(7'h50);
    // drain flag is released only once the pop has been done
    ev(6'h01);
    cs(7'h10);
    wr(`SFL_OFS_CTRL, 32'h0000_0701);
    cs(7'h12);
    // halt in slave mode; a frame size below the minimum is raised to four bits
    wr(`SFL_OFS_CTRL, 32'h0000_0106);
    ev(6'h10);
    // the last loaded entry carries the queue end bit, which slave mode must ignore
    ev(6'h18);
    tc = 0;
    ti = 1;
    u_peer.frame(4);
    rc = 1;
    cs(7'h59);
    // three more frames fill the fifo, one more fills the shifter, the last overflows
    repeat (5) u_peer.frame(4);
    rc = 4;
    cs(7'h79);
    ev(6'h04);
    ri = 2;
    cs(7'h79);
    report_and_stop;
  end
endmodule
